// File: src/nsc_setup_regs.sv
module nsc_setup_regs
  import nsc_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] host_addr_in,
  input  wire logic [2:0] register_window_select_in,
  input  wire logic       host_wr_in,
  input  wire logic       host_rd_in,
  input  wire logic [7:0] host_wdata_in,
  input  wire logic       backplane_mode_in,
  input  wire logic       transmit_enable_in,
  input  wire logic       nonmux_bus_in,
  input  wire logic [7:0] node_id_in,
  input  wire logic       refusal_in,
  input  wire logic       refusal_clear_in,
  input  wire logic       pkt_valid_in,
  input  wire logic [7:0] pkt_dest_id_in,
  input  wire logic       pulse_request_in,
  output logic [7:0]      host_rdata_out,
  output logic            line_pulse_one_out,
  output logic            line_pulse_one_oe_out,
  output logic            excess_refusal_flag_out,
  output logic            accept_pkt_out,
  output logic            send_ack_out,
  output logic            token_allowed_out,
  output logic            rate_tick_out,
  output logic            arb_tick_out,
  output logic            fast_read_active_out
);
  // stored setup bytes
  logic [7:0] setup1_r;
  logic [7:0] setup2_r;
  // refusal counter
  logic [7:0] refuse_cnt_r;
  // rate divider count and arbitration phase
  logic [6:0] rate_cnt_r;
  logic       arb_phase_r;

  // host window decode
  wire        win_hit;
  wire        sel_s1;
  wire        sel_s2;
  wire        wr_s1;
  wire        wr_s2;
  wire [7:0]  rd_mux;
  // setup fields
  wire        fld_pulse_mode;
  wire        fld_short_limit;
  wire        fld_promisc;
  wire [2:0]  fld_rate_sel;
  wire        fld_arb_half;
  wire        fld_fast_read;
  // next values of the registers
  wire [7:0]  setup1_nxt;
  wire [7:0]  setup2_nxt;
  wire [7:0]  refuse_cnt_nxt;
  wire        flag_nxt;
  wire [6:0]  rate_cnt_nxt;
  wire        arb_phase_nxt;
  wire        arb_tick_nxt;
  wire        pulse_nxt;
  wire        pulse_oe_nxt;
  wire        fast_read_nxt;
  // refusal limit compare
  wire [7:0]  refuse_limit;
  wire        refuse_sat;
  wire        refuse_hit;
  // rate divider wrap
  wire [6:0]  rate_last;
  wire        rate_wrap;
  // pulse driver style
  wire        push_pull;

  // configuration and packet fields shared with the receive filter
  nsc_cfg_if cfg ();

  // divisor minus one for a field value, illegal codes clamp to 128
  function automatic logic [6:0] nsc_div_last(input logic [2:0] sel);
    logic [2:0] s;
    logic [7:0] div;
    s   = (sel > NSC_RATE_MAX_SEL) ? NSC_RATE_MAX_SEL : sel;
    div = 8'h01 << (s + NSC_RATE_BASE_SHIFT);
    return 7'(div - 8'h01);
  endfunction : nsc_div_last

  // write data with reserved positions forced to zero
  function automatic logic [7:0] nsc_masked(input logic [7:0] data, input logic [7:0] mask);
    return data & mask;
  endfunction : nsc_masked

  assign win_hit = (host_addr_in == NSC_HOST_ADDR_SETUP);
  assign sel_s1  = win_hit & (register_window_select_in == NSC_SEL_SETUP1);
  assign sel_s2  = win_hit & (register_window_select_in == NSC_SEL_SETUP2);
  assign wr_s1   = sel_s1 & host_wr_in;
  assign wr_s2   = sel_s2 & host_wr_in;

  // read selection, unmapped selector codes read as zero
  assign rd_mux  = sel_s1 ? setup1_r : (sel_s2 ? setup2_r : 8'h00);

  // field extraction from the stored bytes
  assign fld_pulse_mode  = setup1_r[NSC_S1_PULSE_BIT];
  assign fld_short_limit = setup1_r[NSC_S1_SHORT_BIT];
  assign fld_promisc     = setup1_r[NSC_S1_PROMISC_BIT];
  assign fld_rate_sel    = setup1_r[NSC_S1_RATE_LSB +: 3];
  assign fld_arb_half    = setup1_r[NSC_S1_ARB_BIT];
  assign fld_fast_read   = setup2_r[NSC_S2_FAST_BIT];

  assign setup1_nxt = wr_s1 ? nsc_masked(host_wdata_in, NSC_S1_WRITE_MASK) : setup1_r;
  assign setup2_nxt = wr_s2 ? nsc_masked(host_wdata_in, NSC_S2_WRITE_MASK) : setup2_r;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      setup1_r <= NSC_S1_RESET;
    end else begin
      setup1_r <= setup1_nxt;
    end
  end

  // second setup byte storage
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      setup2_r <= NSC_S2_RESET;
    end else begin
      setup2_r <= setup2_nxt;
    end
  end

  // read data registered one cycle after the strobe, held until the next read
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_rdata_out <= 8'h00;
    end else if (host_rd_in) begin
      host_rdata_out <= rd_mux;
    end
  end

  // four refusals when short limit set
  assign refuse_limit = fld_short_limit ? NSC_REFUSE_SHORT : NSC_REFUSE_LONG;
  assign refuse_sat   = (refuse_cnt_r == 8'hff);
  assign refuse_hit   = refusal_in & (refuse_sat | ((refuse_cnt_r + 8'h01) >= refuse_limit));

  // count saturates at its top; a clear restarts it
  assign refuse_cnt_nxt = refusal_clear_in             ? 8'h00 :
                          (refusal_in && !refuse_sat) ? refuse_cnt_r + 8'h01 :
                          refuse_cnt_r;
  // a new hit wins over a clear in the same cycle
  assign flag_nxt = refuse_hit ? 1'b1 : (refusal_clear_in ? 1'b0 : excess_refusal_flag_out);

  // refusal counter
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refuse_cnt_r <= 8'h00;
    end else begin
      refuse_cnt_r <= refuse_cnt_nxt;
    end
  end

  // sticky excess refusal flag
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      excess_refusal_flag_out <= 1'b0;
    end else begin
      excess_refusal_flag_out <= flag_nxt;
    end
  end

  assign rate_last    = nsc_div_last(fld_rate_sel);
  assign rate_wrap    = (rate_cnt_r >= rate_last);
  assign rate_cnt_nxt = rate_wrap ? 7'h00 : rate_cnt_r + 7'h01;

  // rate divider count
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rate_cnt_r <= 7'h00;
    end else begin
      rate_cnt_r <= rate_cnt_nxt;
    end
  end

  // rate enable pulse, one cycle per divisor period
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rate_tick_out <= 1'b0;
    end else begin
      rate_tick_out <= rate_wrap;
    end
  end

  // halved arbitration enables every second cycle
  assign arb_phase_nxt = fld_arb_half ? ~arb_phase_r : 1'b0;
  assign arb_tick_nxt  = fld_arb_half ? arb_phase_r : 1'b1;

  // arbitration phase
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arb_phase_r <= 1'b0;
    end else begin
      arb_phase_r <= arb_phase_nxt;
    end
  end

  // arbitration enable
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arb_tick_out <= 1'b0;
    end else begin
      arb_tick_out <= arb_tick_nxt;
    end
  end

  // push-pull when set or outside backplane mode
  assign push_pull    = fld_pulse_mode | ~backplane_mode_in;
  // open drain only enables the pin while a pulse is wanted, data low
  assign pulse_nxt    = push_pull & pulse_request_in;
  assign pulse_oe_nxt = push_pull | pulse_request_in;

  // pulse pin data
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_pulse_one_out <= 1'b0;
    end else begin
      line_pulse_one_out <= pulse_nxt;
    end
  end

  // pulse pin enable
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_pulse_one_oe_out <= 1'b0;
    end else begin
      line_pulse_one_oe_out <= pulse_oe_nxt;
    end
  end

  // reads on the plain bus only
  assign fast_read_nxt = fld_fast_read & nonmux_bus_in & host_rd_in;

  // read timing output
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fast_read_active_out <= 1'b0;
    end else begin
      fast_read_active_out <= fast_read_nxt;
    end
  end

  // receive filter wiring
  assign cfg.promiscuous_receive = fld_promisc;
  assign cfg.transmit_enable     = transmit_enable_in;
  assign cfg.node_id             = node_id_in;
  assign cfg.pkt_valid           = pkt_valid_in;
  assign cfg.pkt_dest_id         = pkt_dest_id_in;

  // destination filter and acknowledge decision
  nsc_rx_filter u_filter (
    .cfg (cfg.filt)
  );

  // registered accept result
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accept_pkt_out <= 1'b0;
    end else begin
      accept_pkt_out <= cfg.accept_pkt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      send_ack_out <= 1'b0;
    end else begin
      send_ack_out <= cfg.send_ack;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      token_allowed_out <= 1'b0;
    end else begin
      token_allowed_out <= cfg.token_allowed;
    end
  end
endmodule : nsc_setup_regs

// File: src/nsc_pkg.sv
package nsc_pkg;
  // host register window
  localparam logic [2:0] NSC_HOST_ADDR_SETUP  = 3'h7;
  localparam logic [2:0] NSC_SEL_SETUP1       = 3'h2;
  localparam logic [2:0] NSC_SEL_SETUP2       = 3'h4;
  // line_and_rate_setup field positions
  localparam int         NSC_S1_PULSE_BIT     = 7;
  localparam int         NSC_S1_SHORT_BIT     = 6;
  localparam int         NSC_S1_PROMISC_BIT   = 4;
  localparam int         NSC_S1_RATE_LSB      = 1;
  localparam int         NSC_S1_ARB_BIT       = 0;
  // bus_timing_setup field position
  localparam int         NSC_S2_FAST_BIT      = 7;
  // reset values and write masks
  localparam logic [7:0] NSC_S1_RESET         = 8'h00;
  localparam logic [7:0] NSC_S2_RESET         = 8'h00;
  localparam logic [7:0] NSC_S1_WRITE_MASK    = 8'hdf;
  localparam logic [7:0] NSC_S2_WRITE_MASK    = 8'h80;
  // refusal limits
  localparam logic [7:0] NSC_REFUSE_SHORT     = 8'h04;
  localparam logic [7:0] NSC_REFUSE_LONG      = 8'h80;
  // rate divider
  localparam logic [2:0] NSC_RATE_MAX_SEL     = 3'h4;
  localparam logic [2:0] NSC_RATE_BASE_SHIFT  = 3'h3;
endpackage : nsc_pkg

// File: src/nsc_cfg_if.sv
interface nsc_cfg_if;
  logic       promiscuous_receive;
  logic       transmit_enable;
  logic [7:0] node_id;
  logic       pkt_valid;
  logic [7:0] pkt_dest_id;
  logic       accept_pkt;
  logic       send_ack;
  logic       token_allowed;
  modport ctrl (output promiscuous_receive, output transmit_enable, output node_id,
                output pkt_valid, output pkt_dest_id,
                input accept_pkt, input send_ack, input token_allowed);
  modport filt (input promiscuous_receive, input transmit_enable, input node_id,
                input pkt_valid, input pkt_dest_id,
                output accept_pkt, output send_ack, output token_allowed);
endinterface : nsc_cfg_if

// File: src/nsc_rx_filter.sv
module nsc_rx_filter
  import nsc_pkg::*;
(
  nsc_cfg_if.filt cfg
);
  wire dest_match;

  // own-address compare
  assign dest_match = (cfg.pkt_dest_id == cfg.node_id);
  assign cfg.accept_pkt = cfg.pkt_valid & (dest_match | cfg.promiscuous_receive);
  assign cfg.send_ack = cfg.pkt_valid & dest_match;
  assign cfg.token_allowed = cfg.transmit_enable;
endmodule : nsc_rx_filter

// File: tb/nsc_setup_checker.sv
module nsc_setup_checker (
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic       host_rd_in,
  input wire logic       transmit_enable_in,
  input wire logic       nonmux_bus_in,
  input wire logic [7:0] node_id_in,
  input wire logic       refusal_clear_in,
  input wire logic       pkt_valid_in,
  input wire logic [7:0] pkt_dest_id_in,
  input wire logic       excess_refusal_flag_out,
  input wire logic       accept_pkt_out,
  input wire logic       send_ack_out,
  input wire logic       token_allowed_out,
  input wire logic       rate_tick_out,
  input wire logic       arb_tick_out,
  input wire logic       fast_read_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // packet addressed to this node
  sequence own_pkt;
    pkt_valid_in && pkt_dest_id_in == node_id_in;
  endsequence
  // packet, token, clock, read-timing and refusal flag relations
  chk_ack_own:
    assert property (own_pkt |=> accept_pkt_out && send_ack_out) else $error("own pkt lost");
  chk_ack_other:
    assert property (pkt_valid_in && pkt_dest_id_in != node_id_in |=> !send_ack_out)
    else $error("ack for other node");
  chk_pkt_quiet:
    assert property (!pkt_valid_in |=> !accept_pkt_out && !send_ack_out) else $error("stray pkt");
  chk_token_idle:
    assert property (!transmit_enable_in |=> !token_allowed_out) else $error("token when off");
  chk_fast_rd_only:
    assert property (!(host_rd_in && nonmux_bus_in) |=> !fast_read_active_out)
    else $error("fast timing off read");
  chk_arb_no_gap:
    assert property (!arb_tick_out |=> arb_tick_out) else $error("arb tick gap");
  chk_rate_gap:
    assert property (rate_tick_out |=> !rate_tick_out [*7]) else $error("rate tick early");
  chk_flag_sticky:
    assert property (excess_refusal_flag_out && !refusal_clear_in |=> excess_refusal_flag_out)
    else $error("flag dropped");
endmodule : nsc_setup_checker

bind nsc_setup_regs nsc_setup_checker u_nsc_setup_checker (.*);

// File: tb/test_network_setup_config.sv
module test_network_setup_config import nsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk_in, rst_n_in, host_wr_in, host_rd_in, pulse_request_in, pkt_valid_in;
  logic       backplane_mode_in, transmit_enable_in, nonmux_bus_in, refusal_in;
  logic       refusal_clear_in, line_pulse_one_out, line_pulse_one_oe_out, send_ack_out;
  logic       excess_refusal_flag_out, accept_pkt_out, token_allowed_out, rate_tick_out;
  logic       arb_tick_out, fast_read_active_out;
  logic [2:0] host_addr_in, register_window_select_in;
  logic [7:0] host_wdata_in, node_id_in, pkt_dest_id_in, host_rdata_out;
  int         n_fail, checked;
  nsc_setup_regs u_nsc_setup_regs (.*);
  // clock source
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic complete_run;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic [2:0] s, input logic [7:0] d, input logic w);
    @(posedge sys_clk_in);
    host_addr_in <= NSC_HOST_ADDR_SETUP;
    register_window_select_in <= s;
    host_wdata_in <= d;
    host_wr_in <= w;
    host_rd_in <= !w;
    @(posedge sys_clk_in);
    {host_wr_in, host_rd_in} <= 2'h0;
    #1 if (!w) chk(host_rdata_out, d);
  endtask : acc
  task automatic refuse(input int n, input logic e);
    @(posedge sys_clk_in);
    refusal_in <= 1'b1;
    repeat (n) @(posedge sys_clk_in);
    refusal_in <= 1'b0;
    #1 chk({7'h00, excess_refusal_flag_out}, {7'h00, e});
  endtask : refuse
  task automatic pkt(input logic [7:0] d, input logic [1:0] e);
    @(posedge sys_clk_in);
    pkt_valid_in <= 1'b1;
    pkt_dest_id_in <= d;
    @(posedge sys_clk_in);
    pkt_valid_in <= 1'b0;
    #1 chk({6'h00, accept_pkt_out, send_ack_out}, {6'h00, e});
  endtask : pkt
  task automatic tick(output int k);
    k = 0;
    do begin
      @(posedge sys_clk_in);
      #1 k++;
    end while (rate_tick_out !== 1'b1 && k < 300);
    if (k >= 300) begin
      n_fail++;
      complete_run();
    end
  endtask : tick
  // scenarios
  task automatic t_regs;
    acc(NSC_SEL_SETUP1, 8'h00, 1'b0);
    acc(NSC_SEL_SETUP2, 8'h00, 1'b0);
    acc(NSC_SEL_SETUP1, 8'hd9, 1'b1);
    acc(NSC_SEL_SETUP2, 8'hff, 1'b1);
    acc(3'h5, 8'hff, 1'b1);
    acc(3'h5, 8'h00, 1'b0);
    acc(NSC_SEL_SETUP1, 8'hd9, 1'b0);
    acc(NSC_SEL_SETUP2, 8'h80, 1'b0);
    $display("regs done");
  endtask : t_regs
  task automatic t_refuse;
    acc(NSC_SEL_SETUP1, 8'h40, 1'b1);
    refuse(3, 1'b0);
    refuse(1, 1'b1);
    @(posedge sys_clk_in);
    refusal_clear_in <= 1'b1;
    @(posedge sys_clk_in);
    refusal_clear_in <= 1'b0;
    #1 chk({7'h00, excess_refusal_flag_out}, 8'h00);
    acc(NSC_SEL_SETUP1, 8'h00, 1'b1);
    refuse(127, 1'b0);
    refuse(1, 1'b1);
    $display("refusal done");
  endtask : t_refuse
  task automatic t_rate;
    int k;
    for (int c = 0; c < 6; c++) begin
      acc(NSC_SEL_SETUP1, 8'(c << 1), 1'b1);
      tick(k);
      tick(k);
      chk(8'(k), (c > 4) ? 8'h80 : 8'(8 << c));
    end
    $display("rate done");
  endtask : t_rate
  task automatic t_pkt;
    acc(NSC_SEL_SETUP1, 8'h11, 1'b1);
    pkt(8'h33, 2'h2);
    pkt(8'h21, 2'h3);
    acc(NSC_SEL_SETUP1, 8'h00, 1'b1);
    pkt(8'h33, 2'h0);
    pkt(8'h21, 2'h3);
    $display("packet done");
  endtask : t_pkt
  task automatic t_pins;
    int a;
    // halving allowed at any multiplier speed
    acc(NSC_SEL_SETUP1, 8'h01, 1'b1);
    a = 0;
    repeat (8) begin
      @(posedge sys_clk_in);
      #1 a += int'(arb_tick_out);
    end
    chk(8'(a), 8'h04);
    acc(NSC_SEL_SETUP1, 8'h00, 1'b1);
    a = 0;
    repeat (8) begin
      @(posedge sys_clk_in);
      #1 a += int'(arb_tick_out);
    end
    chk(8'(a), 8'h08);
    chk({6'h00, line_pulse_one_out, line_pulse_one_oe_out}, 8'h01);
    @(posedge sys_clk_in);
    pulse_request_in <= 1'b0;
    @(posedge sys_clk_in);
    #1 chk({6'h00, line_pulse_one_out, line_pulse_one_oe_out}, 8'h00);
    acc(NSC_SEL_SETUP1, 8'h80, 1'b1);
    @(posedge sys_clk_in);
    #1 chk({6'h00, line_pulse_one_out, line_pulse_one_oe_out}, 8'h01);
    @(posedge sys_clk_in);
    pulse_request_in <= 1'b1;
    @(posedge sys_clk_in);
    #1 chk({6'h00, line_pulse_one_out, line_pulse_one_oe_out}, 8'h03);
    acc(NSC_SEL_SETUP1, 8'h10, 1'b1);
    chk({7'h00, token_allowed_out}, 8'h00);
    @(posedge sys_clk_in);
    transmit_enable_in <= 1'b1;
    @(posedge sys_clk_in);
    #1 chk({7'h00, token_allowed_out}, 8'h01);
    @(posedge sys_clk_in);
    transmit_enable_in <= 1'b0;
    acc(NSC_SEL_SETUP2, 8'h80, 1'b0);
    chk({7'h00, fast_read_active_out}, 8'h01);
    acc(NSC_SEL_SETUP2, 8'h80, 1'b1);
    chk({7'h00, fast_read_active_out}, 8'h00);
    @(posedge sys_clk_in);
    nonmux_bus_in <= 1'b0;
    acc(NSC_SEL_SETUP2, 8'h80, 1'b0);
    chk({7'h00, fast_read_active_out}, 8'h00);
    $display("pins done");
  endtask : t_pins
  // reset, then the scenarios in turn
  initial begin
    {host_wr_in, host_rd_in, refusal_in, refusal_clear_in, pkt_valid_in, rst_n_in} = '0;
    {host_addr_in, register_window_select_in, host_wdata_in, pkt_dest_id_in} = '0;
    {backplane_mode_in, nonmux_bus_in, pulse_request_in, transmit_enable_in} = 4'he;
    node_id_in = 8'h21;
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_refuse();
    t_rate();
    t_pkt();
    t_pins();
    complete_run();
  end
endmodule : test_network_setup_config
